/* File: cio_defs.vh */
/*
  Constants for the configurable I/O cell block: encodings of the
  configuration selects and the documented default sizes.
  Assumes it is included by bare name from the design file.
*/
`ifndef CIO_DEFS_VH
`define CIO_DEFS_VH

// output buffer source select (2 bits per cell)
`define CIO_OSRC_DIRECT 2'h0
`define CIO_OSRC_INVERT 2'h1
`define CIO_OSRC_REG 2'h2
`define CIO_OSRC_DEC 2'h3

// pad termination select (2 bits per cell)
`define CIO_TERM_NONE 2'h0
`define CIO_TERM_UP 2'h1
`define CIO_TERM_DOWN 2'h2

// core input connection select (2 bits per connection)
`define CIO_ISRC_RAW 2'h0
`define CIO_ISRC_MASTER 2'h1
`define CIO_ISRC_SLAVE 2'h2

// default sizes of one chip edge
`define CIO_NUM_IO 8
`define CIO_NUM_LOCAL 4
`define CIO_NUM_DEC 4
`define CIO_NUM_DEC_SMALL 2

`endif

/* File: cio_block.v */
/*
  One chip edge of configurable I/O cells with their wide edge decoders.
  Each cell has an output path (direct, inverted, registered or decoder
  source, three-state with selectable polarity), an input path with an
  optional capture delay and a master/slave input flip-flop, and pad
  termination control. The edge carries a set of wide AND decoders.
  Assumes: configuration bits are static levels from the configuration
  logic on clk; cfg_done and gsr come from logic on clk; the per-cell
  flip-flop clocks are core signals on clk, sampled for edges; pad_in is
  asynchronous. The pad wire itself is resolved outside from pad_oe.
*/
// How it works
// RULE1: output source is direct, inverted or registered
// RULE2: each flip-flop starts at its configured initial value
// RULE3: global set/reset forces flip-flops to initial value
// RULE4: per flip-flop clock edge selected by polarity
// RULE5: three-state control polarity selectable per cell
// RULE6: pull-up/down/none; pull-up always during configuration
// RULE7: pad input feeds core and input flip-flop
// RULE8: input capture delayed unless fast option set
// RULE9: each core input is raw, master or slave
// RULE10: four decoders per edge, two on small variant
// RULE11: decoder inputs are first input paths plus locals
// RULE12: decoder output high only when AND term true
// RULE13: each decoder splits at midpoint into halves
// RULE14: decoder outputs reach core and output pads
// RULE15: disabled three-state releases pad, else drives it
`timescale 1ns/1ps
`include "cio_defs.vh"

module cio_block
#(
  parameter NUM_IO = `CIO_NUM_IO,
  parameter NUM_LOCAL = `CIO_NUM_LOCAL,
  parameter NUM_DEC = `CIO_NUM_DEC,
  parameter SMALL_VARIANT = 0
)
(
  input wire clk,
  input wire rst_n,
  input wire cfg_done,
  input wire gsr,
  input wire [NUM_IO-1:0] core_out,
  input wire [NUM_IO-1:0] core_t,
  input wire [NUM_IO-1:0] out_clk,
  input wire [NUM_IO-1:0] in_clk,
  input wire [2*NUM_IO-1:0] out_sel,
  input wire [NUM_IO-1:0] t_pol,
  input wire [NUM_IO-1:0] out_clk_pol,
  input wire [NUM_IO-1:0] in_clk_pol,
  input wire [NUM_IO-1:0] out_init,
  input wire [NUM_IO-1:0] in_init,
  input wire [NUM_IO-1:0] fast_input_capture_option,
  input wire [2*NUM_IO-1:0] term_sel,
  input wire [2*NUM_IO-1:0] path_first_sel,
  input wire [2*NUM_IO-1:0] path_second_sel,
  input wire [NUM_IO-1:0] pad_in,
  output wire [NUM_IO-1:0] pad_out,
  output wire [NUM_IO-1:0] pad_oe,
  output wire [NUM_IO-1:0] pad_pull_up,
  output wire [NUM_IO-1:0] pad_pull_down,
  output wire [NUM_IO-1:0] input_path_first,
  output wire [NUM_IO-1:0] input_path_second,
  input wire [NUM_LOCAL-1:0] dec_local,
  input wire [NUM_DEC*(NUM_IO+NUM_LOCAL)-1:0] dec_sel,
  input wire [NUM_DEC*(NUM_IO+NUM_LOCAL)-1:0] dec_inv,
  input wire [NUM_DEC-1:0] dec_split,
  output wire [2*NUM_DEC-1:0] dec_out
);

  localparam DW = NUM_IO + NUM_LOCAL;
  // decoders actually built on this variant
  localparam DEC_ACTIVE = SMALL_VARIANT ? `CIO_NUM_DEC_SMALL : NUM_DEC;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // wide AND of the selected inputs, each optionally inverted;
  // an empty selection reads high, like an unloaded pulled-up line
  function dec_and;
    input [DW-1:0] v;
    input [DW-1:0] sel;
    input [DW-1:0] inv;
    begin
      dec_and = &((v ^ inv) | ~sel);
    end
  endfunction

  // core input connection mux, shared by both connections of a cell
  function in_mux;
    input [1:0] sel;
    input raw;
    input master;
    input slave;
    begin
      case (sel)
        `CIO_ISRC_MASTER: in_mux = master;
        `CIO_ISRC_SLAVE: in_mux = slave;
        default: in_mux = raw;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release: asserted at once, released through two flip-flops

  reg rst_s1_reg;
  reg rst_n_sync_reg;

  // release is synchronised so no flip-flop sees a ragged deassertion
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_n_sync_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n_sync_reg <= rst_s1_reg;
    end
  end

  // flip-flops held at their initial value while unconfigured or in gsr
  wire force_init = ~cfg_done | gsr; // RULE2 RULE3

  ////////////////////////////////////////////////////////////////////////
  // decoder input vector and midpoint mask

  reg [NUM_IO-1:0] path_first_reg;
  reg [NUM_IO-1:0] path_second_reg;
  reg [2*NUM_DEC-1:0] dec_out_reg;

  // first input paths of this edge plus one local line per row/column
  wire [DW-1:0] dec_vec = {dec_local, path_first_reg}; // RULE11

  // lower half: first half of the pads and first half of the locals
  wire [DW-1:0] lo_mask;
  genvar m;
  generate
    for (m = 0; m < DW; m = m + 1)
    begin : g_mask
      if (m < NUM_IO)
      begin : g_io
        assign lo_mask[m] = (m < NUM_IO / 2);
      end
      else
      begin : g_loc
        assign lo_mask[m] = (m - NUM_IO < NUM_LOCAL / 2);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // wide edge decoders

  genvar d;
  generate
    for (d = 0; d < NUM_DEC; d = d + 1)
    begin : g_dec
      wire [DW-1:0] sel = dec_sel[d*DW +: DW];
      wire [DW-1:0] inv = dec_inv[d*DW +: DW];
      wire full = dec_and(dec_vec, sel, inv); // RULE12
      wire lo = dec_and(dec_vec, sel & lo_mask, inv);
      wire hi = dec_and(dec_vec, sel & ~lo_mask, inv);

      // a split decoder gives two independent halves; unsplit, both
      // outputs carry the full term; unbuilt decoders read low
      always @(posedge clk or negedge rst_n_sync_reg)
      begin
        if (!rst_n_sync_reg)
          dec_out_reg[2*d +: 2] <= 2'h0;
        else if (d >= DEC_ACTIVE) // RULE10
          dec_out_reg[2*d +: 2] <= 2'h0;
        else if (dec_split[d]) // RULE13
          dec_out_reg[2*d +: 2] <= {hi, lo};
        else
          dec_out_reg[2*d +: 2] <= {full, full}; // RULE12
      end
    end
  endgenerate

  // decoder outputs go to the core for further combination
  assign dec_out = dec_out_reg; // RULE14

  ////////////////////////////////////////////////////////////////////////
  // I/O cells

  reg [NUM_IO-1:0] pad_out_reg;
  reg [NUM_IO-1:0] pad_oe_reg;
  reg [NUM_IO-1:0] pull_up_reg;
  reg [NUM_IO-1:0] pull_down_reg;

  genvar i;
  generate
    for (i = 0; i < NUM_IO; i = i + 1)
    begin : g_cell
      reg pad_s1_reg;
      reg pad_s2_reg;
      reg pad_dly_reg;
      reg in_eff_q_reg;
      reg out_eff_q_reg;
      reg master_reg;
      reg slave_reg;
      reg out_ff_reg;
      reg osrc_next;
      reg edge_armed_reg;

      // clock seen through its polarity bit: the active edge is always
      // a rise of the effective clock
      wire in_eff = in_clk[i] ^ in_clk_pol[i]; // RULE4
      wire out_eff = out_clk[i] ^ out_clk_pol[i]; // RULE4
      // no history on the first cycle out of reset: take no edge there
      wire in_edge = in_eff & ~in_eff_q_reg & edge_armed_reg;
      wire out_edge = out_eff & ~out_eff_q_reg & edge_armed_reg;

      // the default path takes one extra stage; the fast option trades
      // hold margin for a shorter capture window
      wire cap_d = fast_input_capture_option[i] ? pad_s2_reg :
        pad_dly_reg; // RULE8
      wire [1:0] osel = out_sel[2*i +: 2];
      wire [1:0] term = term_sel[2*i +: 2];
      // after polarity, a high control means the driver is disabled
      wire t_dis = core_t[i] ^ t_pol[i]; // RULE5

      // pad synchroniser and capture delay stage
      always @(posedge clk or negedge rst_n_sync_reg)
      begin
        if (!rst_n_sync_reg)
        begin
          pad_s1_reg <= 1'b0;
          pad_s2_reg <= 1'b0;
          pad_dly_reg <= 1'b0;
          in_eff_q_reg <= 1'b0;
          out_eff_q_reg <= 1'b0;
          edge_armed_reg <= 1'b0;
        end
        else
        begin
          pad_s1_reg <= pad_in[i];
          pad_s2_reg <= pad_s1_reg;
          pad_dly_reg <= pad_s2_reg;
          in_eff_q_reg <= in_eff;
          out_eff_q_reg <= out_eff;
          edge_armed_reg <= 1'b1;
        end
      end

      // input flip-flop: master transparent in the inactive phase,
      // slave loads the master on the active edge
      always @(posedge clk or negedge rst_n_sync_reg)
      begin
        if (!rst_n_sync_reg)
        begin
          master_reg <= 1'b0;
          slave_reg <= 1'b0;
        end
        else if (force_init)
        begin
          master_reg <= in_init[i]; // RULE2 RULE3
          slave_reg <= in_init[i]; // RULE2 RULE3
        end
        else
        begin
          if (!in_eff)
            master_reg <= cap_d; // RULE7
          if (in_edge)
            slave_reg <= master_reg;
        end
      end

      // output flip-flop
      always @(posedge clk or negedge rst_n_sync_reg)
      begin
        if (!rst_n_sync_reg)
          out_ff_reg <= 1'b0;
        else if (force_init)
          out_ff_reg <= out_init[i]; // RULE2 RULE3
        else if (out_edge)
          out_ff_reg <= core_out[i];
      end

      // output source select; decoder source maps cells onto halves
      always @*
      begin
        case (osel)
          `CIO_OSRC_DIRECT: osrc_next = core_out[i]; // RULE1
          `CIO_OSRC_INVERT: osrc_next = ~core_out[i]; // RULE1
          `CIO_OSRC_REG: osrc_next = out_ff_reg; // RULE1
          `CIO_OSRC_DEC: osrc_next = dec_out_reg[i % (2*NUM_DEC)]; // RULE14
          default: osrc_next = core_out[i];
        endcase
      end

      // pad driver, termination and core input connections
      always @(posedge clk or negedge rst_n_sync_reg)
      begin
        if (!rst_n_sync_reg)
        begin
          pad_out_reg[i] <= 1'b0;
          pad_oe_reg[i] <= 1'b0;
          pull_up_reg[i] <= 1'b1;
          pull_down_reg[i] <= 1'b0;
          path_first_reg[i] <= 1'b0;
          path_second_reg[i] <= 1'b0;
        end
        else
        begin
          pad_out_reg[i] <= osrc_next;
          // nothing drives the pad before configuration is done
          pad_oe_reg[i] <= cfg_done & ~t_dis; // RULE15
          // pull-up is forced while configuring, whatever is chosen
          pull_up_reg[i] <= ~cfg_done | (term == `CIO_TERM_UP); // RULE6
          pull_down_reg[i] <= cfg_done & (term == `CIO_TERM_DOWN); // RULE6
          path_first_reg[i] <= in_mux(path_first_sel[2*i +: 2], pad_s2_reg,
            master_reg, slave_reg); // RULE9 RULE7
          path_second_reg[i] <= in_mux(path_second_sel[2*i +: 2], pad_s2_reg,
            master_reg, slave_reg); // RULE9
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg; // RULE15
  assign pad_pull_up = pull_up_reg;
  assign pad_pull_down = pull_down_reg;
  assign input_path_first = path_first_reg;
  assign input_path_second = path_second_reg;

endmodule

/* File: cio_block_props.sv */
/* assertions on the cio_block ports, bound below
   assumes one clock clk and async active-low rst_n */
`timescale 1ns/1ps
module cio_block_props
#(
  parameter NUM_IO = 8,
  parameter NUM_LOCAL = 4,
  parameter NUM_DEC = 4
)
(
  input wire clk,
  input wire rst_n,
  input wire cfg_done,
  input wire gsr,
  input wire [NUM_IO-1:0] core_out,
  input wire [NUM_IO-1:0] core_t,
  input wire [2*NUM_IO-1:0] out_sel,
  input wire [NUM_IO-1:0] t_pol,
  input wire [NUM_IO-1:0] out_init,
  input wire [2*NUM_IO-1:0] term_sel,
  input wire [2*NUM_IO-1:0] path_first_sel,
  input wire [NUM_IO-1:0] pad_in,
  input wire [NUM_IO-1:0] pad_out,
  input wire [NUM_IO-1:0] pad_oe,
  input wire [NUM_IO-1:0] pad_pull_up,
  input wire [NUM_IO-1:0] pad_pull_down,
  input wire [NUM_IO-1:0] input_path_first,
  input wire [NUM_LOCAL-1:0] dec_local,
  input wire [NUM_DEC*(NUM_IO+NUM_LOCAL)-1:0] dec_sel,
  input wire [NUM_DEC*(NUM_IO+NUM_LOCAL)-1:0] dec_inv,
  input wire [NUM_DEC-1:0] dec_split,
  input wire [2*NUM_DEC-1:0] dec_out
);
  localparam W = NUM_IO + NUM_LOCAL;
  // per-input terms of decoder 0
  wire [W-1:0] hit = ~dec_sel[W-1:0] |
    ({dec_local, input_path_first} ^ dec_inv[W-1:0]);
  wire full = &hit;
  reg lo;
  reg [2:0] up_reg;
  integer i;
  // low half takes the first half of pads and of locals
  always @*
  begin
    lo = 1'b1;
    for (i = 0; i < W; i = i + 1)
      if (i < NUM_IO / 2 || (i >= NUM_IO && i < NUM_IO + NUM_LOCAL / 2))
        lo = lo & hit[i];
  end
  // internal reset lags rst_n, so wait until history is meaningful
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      up_reg <= 3'h0;
    else if (up_reg != 3'h7)
      up_reg <= up_reg + 3'h1;
  wire live = up_reg == 3'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_out_source:
  assert property (live && $past(cfg_done) && !$past(out_sel[1])
    |-> pad_out[0] == ($past(core_out[0]) ^ $past(out_sel[0])))
    else $error("pad source wrong");
  a_tri_polarity:
  assert property (live && $past(cfg_done)
    |-> pad_oe[4] == !($past(core_t[4]) ^ $past(t_pol[4])))
    else $error("enable polarity wrong");
  a_unconf_pull:
  assert property (live && !$past(cfg_done)
    |-> !pad_oe[0] && pad_pull_up[0] && !pad_pull_down[0])
    else $error("unconfigured pad wrong");
  a_term_select:
  assert property (live && $past(cfg_done) |-> pad_pull_up[1] ==
    ($past(term_sel[3:2]) == 2'h1) && pad_pull_down[1] ==
    ($past(term_sel[3:2]) == 2'h2))
    else $error("termination wrong");
  a_gsr_init:
  assert property (live && $past(gsr, 2) && $past(cfg_done)
    && $past(out_sel[1:0]) == 2'h2
    |-> pad_out[0] == $past(out_init[0], 2))
    else $error("set/reset value wrong");
  a_raw_input:
  assert property (live && $past(path_first_sel[1:0]) == 2'h0
    |-> input_path_first[0] == $past(pad_in[0], 3))
    else $error("raw input wrong");
  a_dec_and:
  assert property (live && !$past(dec_split[0])
    |-> dec_out[1:0] == {2{$past(full)}})
    else $error("decoder term wrong");
  a_dec_half:
  assert property (live && $past(dec_split[0])
    |-> dec_out[0] == $past(lo))
    else $error("decoder half wrong");
endmodule
bind cio_block cio_block_props #(.NUM_IO(NUM_IO),
  .NUM_LOCAL(NUM_LOCAL), .NUM_DEC(NUM_DEC)) u_props (.*);

/* File: cio_pad_model.sv */
/* board side of the pads: drives, pulls or floats each pad
   assumes clk only paces the floating pattern */
`timescale 1ns/1ps
module cio_pad_model(
  input wire clk,
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe,
  input wire [7:0] pad_pull_up,
  input wire [7:0] pad_pull_down,
  input wire [7:0] brd_val,
  input wire [7:0] brd_en,
  output reg [7:0] pad_in
);
  reg [7:0] flt_reg = 8'h00;
  integer i;
  // an open pad has no level, so it flips each cycle
  always @(posedge clk)
    flt_reg <= ~flt_reg;
  // cell drive wins, then board, then pull, then float
  always @*
    for (i = 0; i < 8; i = i + 1)
      pad_in[i] = pad_oe[i] ? pad_out[i] : brd_en[i] ? brd_val[i] :
        pad_pull_up[i] | (flt_reg[i] & ~pad_pull_down[i]);
endmodule

/* File: cio_block_tb.sv */
/* self-checking bench for cio_block with a board model
   assumes the default sizes: 8 cells, 4 locals, 4 decoders */
`timescale 1ns/1ps
module cio_block_tb;
  reg clk = 0, rst_n = 0, cfg_done = 0, gsr = 0;
  reg [7:0] core_out = 0, core_t = 0, out_clk = 0, in_clk = 0, t_pol = 0;
  reg [7:0] out_clk_pol = 0, in_clk_pol = 0, out_init = 0, in_init = 0;
  reg [7:0] fast_input_capture_option = 0, brd_val = 0, brd_en = 0;
  reg [15:0] out_sel = 0, term_sel = 0, path_first_sel = 0;
  reg [15:0] path_second_sel = 0;
  reg [3:0] dec_local = 0, dec_split = 0;
  reg [47:0] dec_sel = 0, dec_inv = 0;
  wire [7:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  wire [7:0] input_path_first, input_path_second, dec_out;
  integer num_errors = 0, comparisons = 0;
  cio_block u_dut (.*);
  cio_pad_model u_pads (.*);
  initial forever #50 clk = ~clk;
  // inputs move 1 ns after the edge so sampling never races
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task summarize;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // unconfigured cells float pulled up, flip-flops sit at init
  task t_cfg;
    begin
      term_sel = 16'h0024;
      out_sel = 16'haaaa;
      out_init = 8'h3c;
      in_init = 8'h0f;
      tick(1);
      chk("oe", 8'h00, pad_oe);
      chk("pulls", 16'hff00, {pad_pull_up, pad_pull_down});
      cfg_done = 1;
      tick(2);
      chk("init", 8'h3c, pad_out);
      chk("pulls", 16'h0204, {pad_pull_up, pad_pull_down});
      chk("oe", 8'hff, pad_oe);
    end
  endtask
  task t_src;
    integer s;
    begin
      core_out = 8'h5a;
      for (s = 0; s < 2; s = s + 1)
      begin
        out_sel = {8{s[1:0]}};
        tick(1);
        chk("src", s ? 8'ha5 : 8'h5a, pad_out);
      end
      core_t = 8'hcc;
      t_pol = 8'hf0;
      tick(1);
      chk("oe", 8'hc3, pad_oe);
    end
  endtask
  // output flip-flop: per-cell active edge, then global set/reset
  task t_reg;
    begin
      out_sel = 16'haaaa;
      out_init = 8'h00;
      out_clk_pol = 8'hf0;
      gsr = 1;
      tick(2);
      gsr = 0;
      chk("gsr", 8'h00, pad_out);
      core_out = 8'hff;
      out_clk = 8'hff;
      tick(2);
      chk("rise", 8'h0f, pad_out);
      out_clk = 8'h00;
      tick(2);
      chk("fall", 8'hff, pad_out);
      out_init = 8'h3c;
      gsr = 1;
      tick(2);
      gsr = 0;
      chk("gsr", 8'h3c, pad_out);
    end
  endtask
  // fast cells see the pad one cycle before delayed ones
  task t_input;
    begin
      core_t = 8'hff;
      t_pol = 8'h00;
      brd_en = 8'hff;
      path_first_sel = 16'h5555;
      fast_input_capture_option = 8'h0f;
      tick(8);
      brd_val = 8'hff;
      tick(3);
      chk("raw", 8'hff, input_path_second);
      tick(1);
      chk("fast", 8'h0f, input_path_first);
      tick(1);
      chk("slow", 8'hff, input_path_first);
      path_second_sel = 16'haaaa;
      tick(1);
      chk("slave", 8'h0f, input_path_second);
      in_clk = 8'hff;
      tick(3);
      chk("slave", 8'hff, input_path_second);
    end
  endtask
  task t_dec;
    begin
      brd_val = 8'h01;
      path_first_sel = 16'h0000;
      dec_local = 4'h1;
      dec_sel[11:0] = 12'h101;
      tick(5);
      chk("and", 8'hff, dec_out);
      dec_inv[0] = 1'b1;
      tick(1);
      chk("and", 8'hfc, dec_out);
      dec_inv[0] = 1'b0;
      dec_sel[11:0] = 12'h081;
      dec_split[0] = 1'b1;
      tick(1);
      chk("half", 8'hfd, dec_out);
      core_out = 8'h00;
      core_t = 8'h00;
      out_sel = 16'h0003;
      tick(1);
      chk("route", 8'h01, pad_out);
    end
  endtask
  initial
  begin
    tick(6);
    rst_n = 1;
    tick(8);
    t_cfg;
    t_src;
    t_reg;
    t_input;
    t_dec;
    summarize;
  end
  // the tests need about 53 cycles; 1000 means a hang
  initial
  begin
    #100000;
    num_errors = num_errors + 1;
    summarize;
  end
endmodule
